//--- acc_core_map.vh
// constants for the accumulator alu core: opcodes, field positions, timing
// assumes plain verilog includes; no processes here
`ifndef ACC_CORE_MAP_VH
`define ACC_CORE_MAP_VH
`define ACC_DATA_W 8
`define ACC_INSTR_W 14
`define ACC_PC_W 13
`define ACC_PMEM_WORDS 4096
`define ACC_RAM_BYTES 192
`define ACC_FADDR_W 9
// data-space map; pc low byte and status live in the file space
`define ACC_SFR_INDF 9'h000
`define ACC_SFR_PCL 9'h002
`define ACC_SFR_STATUS 9'h003
`define ACC_SFR_FSR 9'h004
`define ACC_SFR_PCLATH 9'h00A
`define ACC_RAM_BASE 9'h020
// status bit positions
`define ACC_ST_C 0
`define ACC_ST_NIB 1
`define ACC_ST_Z 2
// alu operation codes
`define ACC_OP_ADD 4'h0
`define ACC_OP_SUB 4'h1
`define ACC_OP_AND 4'h2
`define ACC_OP_IOR 4'h3
`define ACC_OP_XOR 4'h4
`define ACC_OP_RLF 4'h5
`define ACC_OP_RRF 4'h6
`define ACC_OP_COM 4'h7
`define ACC_OP_INC 4'h8
`define ACC_OP_DEC 4'h9
`define ACC_OP_SWAP 4'hA
`define ACC_OP_PASS 4'hB
`define ACC_OP_CLR 4'hC
// timing: instruction cycle figures as printed, and core clock
`define ACC_TCY_NS 200
`define ACC_REF_MHZ 20
`define ACC_CLK_NS 10
`define ACC_CLK_PER_Q 1
`endif

//--- acc_alu.v
// 8-bit alu: add, subtract, shift, logic; produces c, nibble overflow, z
// assumes operand a is the working accumulator, operand b file or literal
`timescale 1ns/1ps
`include "acc_core_map.vh"
module acc_alu #(
    parameter W = 8
) (
    // operation
    input wire [3:0] op,
    input wire [W-1:0] opa,
    input wire [W-1:0] opb,
    input wire carry_in,
    // result
    output reg [W-1:0] res,
    output reg carry_out,
    output reg nibble_out,
    output wire zero_out
);
    reg [W:0] sum;
    reg [4:0] lo;
    always @* begin
        sum = {(W+1){1'b0}};
        lo = 5'h00;
        res = opb;
        carry_out = carry_in;
        nibble_out = 1'b0;
        case (op)
            `ACC_OP_ADD: begin
                sum = {1'b0, opa} + {1'b0, opb};
                lo = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
                res = sum[W-1:0];
                carry_out = sum[W];
                nibble_out = lo[4];
            end
            `ACC_OP_SUB: begin
                // b - a as b + ~a + 1; carry then means no borrow
                sum = {1'b0, opb} + {1'b0, ~opa} + {{W{1'b0}}, 1'b1};
                lo = {1'b0, opb[3:0]} + {1'b0, ~opa[3:0]} + 5'h01;
                res = sum[W-1:0];
                carry_out = sum[W];
                nibble_out = lo[4];
            end
            `ACC_OP_AND: res = opa & opb;
            `ACC_OP_IOR: res = opa | opb;
            `ACC_OP_XOR: res = opa ^ opb;
            `ACC_OP_RLF: begin
                res = {opb[W-2:0], carry_in};
                carry_out = opb[W-1];
            end
            `ACC_OP_RRF: begin
                res = {carry_in, opb[W-1:1]};
                carry_out = opb[0];
            end
            `ACC_OP_COM: res = ~opb;
            `ACC_OP_INC: res = opb + {{(W-1){1'b0}}, 1'b1};
            `ACC_OP_DEC: res = opb - {{(W-1){1'b0}}, 1'b1};
            `ACC_OP_SWAP: res = {opb[3:0], opb[W-1:4]};
            `ACC_OP_CLR: res = {W{1'b0}};
            default: res = opb;
        endcase
    end
    assign zero_out = (res == {W{1'b0}});
endmodule

//--- acc_core.v
// two-stage accumulator core: fetch over a 14-bit program bus, execute on 8-bit data
// assumes program memory answers combinationally on instr_data for the address on pc_out;
// master_reset_n and resistor_capacitor_mode come from pins and are synchronised here
//
// Contract
// - alu works on 8-bit operands with add, subtract, shift and logic
// - arithmetic operands and results are two's complement
// - two-operand ops use accumulator plus a file register or literal
// - single-operand ops use the accumulator or a file register
// - accumulator has no data address; only implicit operand or destination
// - carry, nibble overflow and zero update per instruction, else unchanged
// - in subtraction carry is inverted borrow, nibble flag inverted nibble borrow
// - fetch path is 14 bits, separate from data, one word per cycle
// - two pipeline stages overlap fetch and execute
// - non-branch ops take one cycle; branches take two to refetch
// - status, pc and pointer registers sit in the data address space
// - program space is 4K by 14; general data memory is 192 bytes
// - in resistor-capacitor mode the cycle-rate output runs at a quarter of input clock
// - core stays reset while master_reset_n is low
`timescale 1ns/1ps
`include "acc_core_map.vh"
module acc_core #(
    parameter DW = `ACC_DATA_W,
    parameter IW = `ACC_INSTR_W,
    parameter PW = `ACC_PC_W,
    parameter RAM_N = `ACC_RAM_BYTES
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // pins
    input wire master_reset_n,
    input wire resistor_capacitor_mode,
    output reg cycle_rate_output,
    // program bus
    output reg [PW-1:0] pc_out,
    input wire [IW-1:0] instr_data,
    // observation
    output reg [DW-1:0] acc_out,
    output reg [DW-1:0] status_out
);
    localparam S_RUN = 3'b001;
    localparam S_FLUSH = 3'b010;
    localparam S_HOLD = 3'b100;
    // quarter phases of the input clock; cycle_rate_output toggles every 2 phases
    localparam [1:0] Q_LAST = 2'd3;

    reg [1:0] mr_sync_q;
    reg [1:0] mode_sync_q;
    reg [2:0] state_q;
    reg [1:0] q_cnt_q;
    reg cyc_en_q;
    reg [PW-1:0] pc_q;
    reg [IW-1:0] ir_q;
    reg ir_valid_q;
    reg [DW-1:0] w_q;
    reg [DW-1:0] status_q;
    reg [DW-1:0] fsr_q;
    reg [4:0] pclath_q;
    reg [DW-1:0] ram_q [0:RAM_N-1];

    wire core_rst = ~mr_sync_q[1];
    // pin synchronisers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mr_sync_q <= 2'b00;
            mode_sync_q <= 2'b00;
        end else begin
            mr_sync_q <= {mr_sync_q[0], master_reset_n};
            mode_sync_q <= {mode_sync_q[0], resistor_capacitor_mode};
        end
    end

    // one instruction cycle is four quarter phases; enable once per cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_cnt_q <= 2'd0;
            cyc_en_q <= 1'b0;
            cycle_rate_output <= 1'b0;
        end else if (core_rst) begin
            q_cnt_q <= 2'd0;
            cyc_en_q <= 1'b0;
            cycle_rate_output <= 1'b0;
        end else begin
            q_cnt_q <= q_cnt_q + 2'd1;
            cyc_en_q <= (q_cnt_q == Q_LAST - 2'd1);
            // high in the last phase of each cycle and the first phase of the next, only in resistor-capacitor mode
            cycle_rate_output <= mode_sync_q[1] & q_cnt_q[1];
        end
    end

    // decode of the instruction in execute
    reg [3:0] op;
    reg use_lit;
    reg to_file;
    reg upd_c, upd_nib, upd_z;
    reg is_branch, is_skip_test, bit_op, bit_set, no_write;
    reg [8:0] faddr;
    reg [DW-1:0] fval;
    wire [DW-1:0] lit = ir_q[7:0];
    wire [2:0] bsel = ir_q[9:7];
    always @* begin
        op = `ACC_OP_PASS;
        use_lit = 1'b0;
        to_file = ir_q[7];
        upd_c = 1'b0;
        upd_nib = 1'b0;
        upd_z = 1'b0;
        is_branch = 1'b0;
        is_skip_test = 1'b0;
        bit_op = 1'b0;
        bit_set = 1'b0;
        no_write = 1'b0;
        case (ir_q[13:12])
            2'b00: begin
                case (ir_q[11:8])
                    4'h0: begin
                        no_write = ~ir_q[7];
                        op = `ACC_OP_PASS;
                    end
                    4'h1: begin op = `ACC_OP_CLR; upd_z = 1'b1; end
                    4'h2: begin op = `ACC_OP_SUB; upd_c = 1'b1; upd_nib = 1'b1; upd_z = 1'b1; end
                    4'h3: begin op = `ACC_OP_DEC; upd_z = 1'b1; end
                    4'h4: begin op = `ACC_OP_IOR; upd_z = 1'b1; end
                    4'h5: begin op = `ACC_OP_AND; upd_z = 1'b1; end
                    4'h6: begin op = `ACC_OP_XOR; upd_z = 1'b1; end
                    4'h7: begin op = `ACC_OP_ADD; upd_c = 1'b1; upd_nib = 1'b1; upd_z = 1'b1; end
                    4'h8: begin op = `ACC_OP_PASS; upd_z = 1'b1; end
                    4'h9: begin op = `ACC_OP_COM; upd_z = 1'b1; end
                    4'hA: op = `ACC_OP_INC;
                    4'hB: begin op = `ACC_OP_DEC; is_skip_test = 1'b1; end
                    4'hC: begin op = `ACC_OP_RRF; upd_c = 1'b1; end
                    4'hD: begin op = `ACC_OP_RLF; upd_c = 1'b1; end
                    4'hE: op = `ACC_OP_SWAP;
                    default: begin op = `ACC_OP_INC; is_skip_test = 1'b1; end
                endcase
                if (ir_q[11:8] == 4'hA) upd_z = 1'b1;
            end
            2'b01: begin
                bit_op = ~ir_q[11];
                bit_set = ir_q[10];
                is_skip_test = ir_q[11];
                to_file = ~ir_q[11];
            end
            2'b10: begin
                is_branch = 1'b1;
                to_file = 1'b0;
                no_write = 1'b1;
            end
            default: begin
                use_lit = 1'b1;
                to_file = 1'b0;
                case (ir_q[11:8])
                    4'h8: begin op = `ACC_OP_IOR; upd_z = 1'b1; end
                    4'h9: begin op = `ACC_OP_AND; upd_z = 1'b1; end
                    4'hA: begin op = `ACC_OP_XOR; upd_z = 1'b1; end
                    4'hC, 4'hD: begin op = `ACC_OP_SUB; upd_c = 1'b1; upd_nib = 1'b1; upd_z = 1'b1; end
                    4'hE, 4'hF: begin op = `ACC_OP_ADD; upd_c = 1'b1; upd_nib = 1'b1; upd_z = 1'b1; end
                    default: op = `ACC_OP_PASS;
                endcase
            end
        endcase
        // indirect access goes through the pointer register
        faddr = (ir_q[6:0] == 7'h00) ? {status_q[7], fsr_q} : {status_q[6:5], ir_q[6:0]};
        case ({2'b00, faddr[6:0]})
            `ACC_SFR_INDF: fval = {DW{1'b0}};
            `ACC_SFR_PCL: fval = pc_q[7:0];
            `ACC_SFR_STATUS: fval = status_q;
            `ACC_SFR_FSR: fval = fsr_q;
            `ACC_SFR_PCLATH: fval = {3'b000, pclath_q};
            default: fval = ({2'b00, faddr[6:0]} >= `ACC_RAM_BASE) ? ram_q[ram_idx(faddr)] : {DW{1'b0}};
        endcase
    end

    // maps a file address onto the 192-byte general store: 96 bytes in each of two banks
    function [7:0] ram_idx;
        input [8:0] fa;
        reg [7:0] off;
        begin
            off = {1'b0, fa[6:0]} - 8'h20;
            ram_idx = fa[7] ? off + 8'h60 : off;
        end
    endfunction

    // bank bits dropped: special registers and the store answer in every bank
    wire [8:0] floc = {2'b00, faddr[6:0]};
    // a move from the accumulator must write it out as is; the alu would only pass the file value
    wire mov_w = (ir_q[13:8] == 6'h00);
    wire [DW-1:0] opb = use_lit ? lit : fval;
    wire [DW-1:0] alu_res;
    wire alu_c, alu_nib, alu_z;
    acc_alu #(
        .W(DW)
    ) u_alu (
        .op(op),
        .opa(w_q),
        .opb(opb),
        .carry_in(status_q[`ACC_ST_C]),
        .res(alu_res),
        .carry_out(alu_c),
        .nibble_out(alu_nib),
        .zero_out(alu_z)
    );

    wire bit_now = fval[bsel];
    reg [DW-1:0] bit_res;
    always @* begin
        bit_res = fval;
        bit_res[bsel] = bit_set;
    end
    wire [DW-1:0] wr_val = bit_op ? bit_res : (mov_w ? w_q : alu_res);
    wire skip = is_skip_test & (ir_q[13:12] == 2'b01 ? (bit_now == ir_q[10]) : alu_z);
    wire exec = cyc_en_q & ir_valid_q & (state_q == S_RUN);
    wire take_branch = exec & is_branch;
    wire pcl_wr = exec & ~is_branch & to_file & ~no_write & (floc == `ACC_SFR_PCL);

    integer k;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_HOLD;
            pc_q <= {PW{1'b0}};
            ir_q <= {IW{1'b0}};
            ir_valid_q <= 1'b0;
            w_q <= {DW{1'b0}};
            status_q <= 8'h18;
            fsr_q <= {DW{1'b0}};
            pclath_q <= 5'h00;
        end else if (core_rst) begin
            state_q <= S_HOLD;
            pc_q <= {PW{1'b0}};
            ir_valid_q <= 1'b0;
            status_q <= 8'h18;
            pclath_q <= 5'h00;
        end else if (cyc_en_q) begin
            case (state_q)
                S_HOLD: begin
                    ir_q <= instr_data;
                    ir_valid_q <= 1'b1;
                    pc_q <= pc_q + {{(PW-1){1'b0}}, 1'b1};
                    state_q <= S_RUN;
                end
                S_RUN: begin
                    if (take_branch) begin
                        // fetched word is stale; spend one cycle refetching
                        pc_q <= {pclath_q[4:3], ir_q[10:0]};
                        ir_valid_q <= 1'b0;
                        state_q <= S_FLUSH;
                    end else if (pcl_wr) begin
                        // a computed jump through the low pc byte refetches like a branch
                        pc_q <= {pclath_q, wr_val};
                        ir_valid_q <= 1'b0;
                        state_q <= S_FLUSH;
                    end else begin
                        // fetch next while this one executes
                        ir_q <= skip ? {IW{1'b0}} : instr_data;
                        pc_q <= pc_q + {{(PW-1){1'b0}}, 1'b1};
                    end
                    if (!is_branch) begin
                        if (to_file && !no_write) begin
                            case (floc)
                                `ACC_SFR_STATUS: begin
                                    // flags are writable; an instruction's own flag update below wins
                                    status_q[7:5] <= wr_val[7:5];
                                    status_q[2:0] <= wr_val[2:0];
                                end
                                `ACC_SFR_FSR: fsr_q <= wr_val;
                                `ACC_SFR_PCLATH: pclath_q <= wr_val[4:0];
                                default: ;
                            endcase
                        end else if (!to_file && !bit_op && !no_write && !is_skip_test) begin
                            w_q <= alu_res;
                        end
                        if (upd_c) status_q[`ACC_ST_C] <= alu_c;
                        if (upd_nib) status_q[`ACC_ST_NIB] <= alu_nib;
                        if (upd_z) status_q[`ACC_ST_Z] <= alu_z;
                    end
                end
                S_FLUSH: begin
                    ir_q <= instr_data;
                    ir_valid_q <= 1'b1;
                    pc_q <= pc_q + {{(PW-1){1'b0}}, 1'b1};
                    state_q <= S_RUN;
                end
                default: state_q <= S_HOLD;
            endcase
        end
    end

    // general store has no reset; software initialises it
    always @(posedge clk) begin
        if (exec && !core_rst && !is_branch && to_file && !no_write && floc >= `ACC_RAM_BASE) begin
            for (k = 0; k < RAM_N; k = k + 1) begin
                if (k == ram_idx(faddr)) ram_q[k] <= wr_val;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_out <= {PW{1'b0}};
            acc_out <= {DW{1'b0}};
            status_out <= 8'h18;
        end else begin
            pc_out <= pc_q;
            acc_out <= w_q;
            status_out <= status_q;
        end
    end
endmodule

//--- acc_core_properties.sv
// port-level checks for acc_core: pin synchronisers, cycle pacing, reset values
// assumes a single clock domain and the four-clock instruction cycle of the core
`timescale 1ns/1ps
module acc_core_properties #(
    parameter DW = 8,
    parameter IW = 14,
    parameter PW = 13
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // pins
    input wire master_reset_n,
    input wire resistor_capacitor_mode,
    input wire cycle_rate_output,
    // program bus
    input wire [PW-1:0] pc_out,
    input wire [IW-1:0] instr_data,
    // observation
    input wire [DW-1:0] acc_out,
    input wire [DW-1:0] status_out
);
    reg [3:0] gap_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // clocks since the last fetch address change, saturating
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= 4'h0;
        end else if ($changed(pc_out)) begin
            gap_q <= 4'h0;
        end else if (gap_q != 4'hF) begin
            gap_q <= gap_q + 4'h1;
        end
    end
    // a jump to zero is left out: the master reset also lands there
    pc_gap_a: assert property ($changed(pc_out) && pc_out != {PW{1'b0}} |-> gap_q >= 4'h3)
        else $error("fetch address moved faster than one instruction cycle");
    acc_step_a: assert property ($changed(acc_out) |=> $stable(acc_out) [*3])
        else $error("accumulator changed twice within one instruction cycle");
    status_step_a: assert property ($changed(status_out) && master_reset_n |=> $stable(status_out) [*3])
        else $error("status changed twice within one instruction cycle");
    hold_pc_a: assert property (!master_reset_n [*5] |-> pc_out == {PW{1'b0}})
        else $error("fetch address not cleared under master reset");
    hold_status_a: assert property (!master_reset_n [*5] |-> status_out == 8'h18)
        else $error("status not at reset value under master reset");
    rate_off_low_a: assert property (!resistor_capacitor_mode [*4] |-> !cycle_rate_output)
        else $error("cycle rate output active outside resistor-capacitor mode");
    rate_period_a: assert property ($rose(cycle_rate_output) |-> ##4 $rose(cycle_rate_output))
        else $error("cycle rate output period is not four clocks");
    rate_high_two_a: assert property ($rose(cycle_rate_output) |=> cycle_rate_output ##1 !cycle_rate_output)
        else $error("cycle rate output high time is not two clocks");
endmodule

bind acc_core acc_core_properties #(.DW(DW), .IW(IW), .PW(PW)) i_acc_core_properties (
    .clk(clk), .rst_b(rst_b), .master_reset_n(master_reset_n),
    .resistor_capacitor_mode(resistor_capacitor_mode), .cycle_rate_output(cycle_rate_output),
    .pc_out(pc_out), .instr_data(instr_data), .acc_out(acc_out), .status_out(status_out)
);

//--- acc_prog_model.sv
// program memory model: 4K words of 14 bits, read without a clock
// assumes the bench writes words into mem while the core is held in master reset
`timescale 1ns/1ps
module acc_prog_model (
    // fetch bus
    input wire [12:0] pc_out,
    output wire [13:0] instr_data
);
    reg [13:0] mem [0:4095];
    integer i;
    initial begin
        for (i = 0; i < 4096; i = i + 1) begin
            // unloaded words are a live add, so a stray fetch shows up in the results
            mem[i] = 14'h3FFF;
        end
    end
    assign instr_data = mem[pc_out[11:0]];
endmodule

//--- accumulator_alu_core_datapath_tb_top.sv
// self-checking bench for acc_core: small programs run from the memory model
// assumes four clocks per instruction cycle and a one-clock result delay
`timescale 1ns/1ps
module accumulator_alu_core_datapath_tb_top;
    reg clk;
    reg rst_b;
    reg master_reset_n;
    reg resistor_capacitor_mode;
    wire cycle_rate_output;
    wire [12:0] pc_out;
    wire [13:0] instr_data;
    wire [7:0] acc_out;
    wire [7:0] status_out;
    integer n_errors;
    integer compares;
    integer i;
    integer k;
    integer r;
    reg seen;
    reg [32:0] tab [0:17];

    acc_core i_acc_core (
        .clk(clk), .rst_b(rst_b), .master_reset_n(master_reset_n),
        .resistor_capacitor_mode(resistor_capacitor_mode), .cycle_rate_output(cycle_rate_output),
        .pc_out(pc_out), .instr_data(instr_data), .acc_out(acc_out), .status_out(status_out)
    );
    acc_prog_model i_acc_prog_model (.pc_out(pc_out), .instr_data(instr_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input [95:0] what, input [7:0] exp, input [7:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task ld4(input [11:0] a, input [13:0] w0, input [13:0] w1, input [13:0] w2, input [13:0] w3);
        begin
            i_acc_prog_model.mem[a] = w0;
            i_acc_prog_model.mem[a + 12'h001] = w1;
            i_acc_prog_model.mem[a + 12'h002] = w2;
            i_acc_prog_model.mem[a + 12'h003] = w3;
        end
    endtask

    task prep;
        begin
            @(posedge clk);
            master_reset_n <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask

    task run_to(input [12:0] stop);
        begin
            master_reset_n <= 1'b1;
            k = 0;
            @(negedge clk);
            while (pc_out !== stop && k < 200) begin
                @(negedge clk);
                k = k + 1;
            end
            chk("halt", 8'h00, (k < 200) ? 8'h00 : 8'hFF);
            repeat (16) @(negedge clk);
        end
    endtask

    task wait_acc(input [7:0] v);
        begin
            k = 0;
            while (acc_out !== v && k < 100) begin
                @(negedge clk);
                k = k + 1;
                if (acc_out === 8'h09) seen = 1'b1;
            end
        end
    endtask

    task t_alu;
        begin
            tab[0] = {8'h0F, 14'h3E01, 8'h10, 3'b010};
            tab[1] = {8'hF0, 14'h3E10, 8'h00, 3'b101};
            tab[2] = {8'h01, 14'h3C00, 8'hFF, 3'b000};
            tab[3] = {8'h01, 14'h3C12, 8'h11, 3'b011};
            tab[4] = {8'h80, 14'h3C7F, 8'hFF, 3'b010};
            tab[5] = {8'hC5, 14'h395A, 8'h40, 3'b000};
            tab[6] = {8'hC5, 14'h385A, 8'hDF, 3'b000};
            tab[7] = {8'hC5, 14'h3A5A, 8'h9F, 3'b000};
            tab[8] = {8'hC5, 14'h0922, 8'h3A, 3'b000};
            tab[9] = {8'hC5, 14'h0E22, 8'h5C, 3'b000};
            tab[10] = {8'hC5, 14'h0A22, 8'hC6, 3'b000};
            tab[11] = {8'hC5, 14'h0322, 8'hC4, 3'b000};
            tab[12] = {8'hC5, 14'h0C22, 8'h62, 3'b001};
            tab[13] = {8'hC5, 14'h0D22, 8'h8A, 3'b001};
            tab[14] = {8'hC5, 14'h0722, 8'h8A, 3'b001};
            tab[15] = {8'hC5, 14'h0222, 8'h00, 3'b111};
            tab[16] = {8'hC5, 14'h0100, 8'h00, 3'b100};
            tab[17] = {8'h00, 14'h0822, 8'h00, 3'b100};
            for (i = 0; i < 18; i = i + 1) begin
                prep;
                ld4(12'h000, {6'b110000, tab[i][32:25]}, 14'h00A2, tab[i][24:11], 14'h2803);
                run_to(13'h0003);
                chk("alu_acc", tab[i][10:3], acc_out);
                chk("alu_flags", {5'h00, tab[i][2:0]}, {5'h00, status_out[2:0]});
            end
            $display("test alu done");
        end
    endtask

    task t_time;
        begin
            prep;
            ld4(12'h000, 14'h3001, 14'h3002, 14'h2804, 14'h3009);
            ld4(12'h004, 14'h3003, 14'h2805, 14'h3FFF, 14'h3FFF);
            seen = 1'b0;
            master_reset_n <= 1'b1;
            wait_acc(8'h01);
            wait_acc(8'h02);
            chk("step_clks", 8'h04, k[7:0]);
            wait_acc(8'h03);
            chk("branch_clks", 8'h0C, k[7:0]);
            chk("skipped", 8'h00, {7'h00, seen});
            $display("test timing done");
        end
    endtask

    task t_sfr;
        begin
            prep;
            ld4(12'h000, 14'h3020, 14'h0084, 14'h305A, 14'h0080);
            ld4(12'h004, 14'h0100, 14'h0820, 14'h2806, 14'h3FFF);
            run_to(13'h0006);
            chk("indirect", 8'h5A, acc_out);
            prep;
            ld4(12'h000, 14'h3007, 14'h0083, 14'h0803, 14'h2803);
            run_to(13'h0003);
            chk("status_rd", 8'h07, {5'h00, acc_out[2:0]});
            chk("status_z", 8'h03, {5'h00, status_out[2:0]});
            prep;
            ld4(12'h000, 14'h3005, 14'h0082, 14'h30EE, 14'h2803);
            ld4(12'h004, 14'h3FFF, 14'h3077, 14'h2806, 14'h3FFF);
            run_to(13'h0006);
            chk("pc_write", 8'h77, acc_out);
            prep;
            ld4(12'h000, 14'h3011, 14'h1903, 14'h3022, 14'h2803);
            run_to(13'h0003);
            chk("bit_skip", 8'h11, acc_out);
            $display("test sfr done");
        end
    endtask

    task t_master_reset_n;
        begin
            prep;
            ld4(12'h000, 14'h30FF, 14'h3E02, 14'h2802, 14'h3FFF);
            run_to(13'h0002);
            chk("add_flags", 8'h03, {5'h00, status_out[2:0]});
            prep;
            repeat (20) @(negedge clk);
            chk("held_pc", 8'h00, pc_out[7:0]);
            chk("held_status", 8'h18, status_out);
            chk("held_acc", 8'h01, acc_out);
            run_to(13'h0002);
            chk("rerun_acc", 8'h01, acc_out);
            $display("test master reset done");
        end
    endtask

    task t_rate;
        begin
            k = 0;
            repeat (16) begin
                @(negedge clk);
                k = k + cycle_rate_output;
            end
            chk("rate_off", 8'h00, k[7:0]);
            @(posedge clk);
            resistor_capacitor_mode <= 1'b1;
            repeat (8) @(negedge clk);
            k = 0;
            r = 0;
            seen = cycle_rate_output;
            repeat (16) begin
                @(negedge clk);
                k = k + cycle_rate_output;
                r = r + (cycle_rate_output && !seen);
                seen = cycle_rate_output;
            end
            chk("rate_high", 8'h08, k[7:0]);
            chk("rate_rises", 8'h04, r[7:0]);
            $display("test cycle rate done");
        end
    endtask

    task complete_run;
        begin
            $display("mismatches %0d comparisons %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask

    initial begin
        rst_b = 1'b0;
        master_reset_n = 1'b1;
        resistor_capacitor_mode = 1'b0;
        n_errors = 0;
        compares = 0;
        seen = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_alu;
        t_time;
        t_sfr;
        t_master_reset_n;
        t_rate;
        complete_run;
    end

    // the tests need about 1000 clocks; this leaves ample margin
    initial begin
        #200000;
        n_errors = n_errors + 1;
        $display("CHECK FAILED watchdog expected finish seen hang");
        complete_run;
    end
endmodule
